// *** rcc_defines.vh ***
/*
  Constants of the RTC configuration and calibration block: register
  offsets, field positions, reset values, pointer codes and timebase
  counts. Assumes it is included by its bare name in every design file.
*/
`ifndef RCC_DEFINES_VH
`define RCC_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Avalon slave
`define RCC_OFS_CFG 4'h0
`define RCC_OFS_VAL 4'h4
`define RCC_OFS_PAD 4'h8

// Configuration and calibration field positions
`define RCC_CFG_EN 15
`define RCC_CFG_WREN 13
`define RCC_CFG_HALF 11
`define RCC_CFG_OE 10
`define RCC_CFG_PTR_HI 9
`define RCC_CFG_PTR_LO 8
`define RCC_CFG_CAL_HI 7
`define RCC_CFG_CAL_LO 0
`define RCC_PAD_SEL 1

// Reset values
`define RCC_CAL_RST 8'h00
`define RCC_PTR_RST 2'h0

// Window pointer codes
`define RCC_PTR_MIN_SEC 2'h0
`define RCC_PTR_WDHR 2'h1
`define RCC_PTR_MTHDAY 2'h2
`define RCC_PTR_YEAR 2'h3

////////////////////////////////////////////////////////////////////////
// Timebase: reference clock rate and timebase pulses per second
`define RCC_CLK_HZ 20000000
`define RCC_TB_HZ 32768
`define RCC_TB_DIV (`RCC_CLK_HZ / `RCC_TB_HZ)

// Calendar limits
`define RCC_SEC_MAX 8'h3b
`define RCC_MIN_MAX 8'h3b
`define RCC_HR_MAX 8'h17
`define RCC_WD_MAX 8'h06
`define RCC_MON_MAX 8'h0c
`define RCC_YR_MAX 8'h63

`endif

// *** rcc_prescale.v ***
/*
  Timebase divider and sub-second counter. Holds a divider that makes
  raw timebase pulses from the reference clock, and a counter of
  calibrated pulses that marks whole seconds and the half-second.
  Assumes the calibrated pulse comes back from the adjust stage on the
  same clock.
*/
`include "rcc_defines.vh"
module rcc_prescale #(
  parameter TB_DIV = `RCC_TB_DIV,
  parameter TB_PER_SEC = `RCC_TB_HZ
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire run,
  input wire adj_tick,
  input wire sub_clr,
  output wire raw_tick,
  output wire sec_evt,
  output wire half_flag
);
  localparam DW = $clog2(TB_DIV);
  localparam SW = $clog2(TB_PER_SEC);
  localparam integer DIV_LAST_I = TB_DIV - 1;
  localparam integer SUB_LAST_I = TB_PER_SEC - 1;
  localparam integer SUB_HALF_I = TB_PER_SEC / 2;
  // Cut to counter width on purpose; the values always fit
  localparam [DW-1:0] DIV_LAST = DIV_LAST_I[DW-1:0];
  localparam [SW-1:0] SUB_LAST = SUB_LAST_I[SW-1:0];
  localparam [SW-1:0] SUB_HALF = SUB_HALF_I[SW-1:0];

  reg [DW-1:0] div_q; // Reference cycles within a pulse
  reg [SW-1:0] sub_q; // Calibrated pulses within a second

  assign raw_tick = run & (div_q == DIV_LAST);
  assign sec_evt = adj_tick & (sub_q == SUB_LAST);
  assign half_flag = (sub_q >= SUB_HALF);

  ////////////////////////////////////////////////////////////////////
  // Divider stalls while the module is disabled
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      div_q <= {DW{1'b0}};
    else if (raw_tick)
      div_q <= {DW{1'b0}};
    else if (run)
      div_q <= div_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // Sub-second counter; a seconds write restarts the second
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      sub_q <= {SW{1'b0}};
    else if (sub_clr)
      sub_q <= {SW{1'b0}};
    else if (sec_evt)
      sub_q <= {SW{1'b0}};
    else if (adj_tick)
      sub_q <= sub_q + 1'b1;
  end
endmodule

// *** rcc_cal_adjust.v ***
/*
  Drift calibration stage. At each minute boundary it loads the signed
  calibration times four, then inserts or swallows timebase pulses until
  that budget is spent. Assumes raw pulses are far rarer than reference
  cycles, so an inserted pulse always finds an empty cycle.
*/
`include "rcc_defines.vh"
module rcc_cal_adjust (
  input wire ref_clk,
  input wire sys_rst,
  input wire run,
  input wire raw_tick,
  input wire minute_evt,
  input wire [7:0] cal,
  output wire adj_tick
);
  reg signed [10:0] pend_q; // Pulses still to add (+) or drop (-)
  wire add_now;
  wire drop_now;

  // Insert only in a cycle without a natural pulse
  assign add_now = run & ~raw_tick & ~pend_q[10] & (pend_q != 11'h000);
  assign drop_now = raw_tick & pend_q[10];
  assign adj_tick = (raw_tick & ~drop_now) | add_now;

  ////////////////////////////////////////////////////////////////////
  // Budget: cal * 4, from -512 up to +508, zero means untouched
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      pend_q <= 11'h000;
    else if (minute_evt)
      pend_q <= {cal[7], cal, 2'b00};
    else if (add_now)
      pend_q <= pend_q - 11'sh001;
    else if (drop_now)
      pend_q <= pend_q + 11'sh001;
  end
endmodule

// *** rcc_top.v ***
/*
  RTC configuration and calibration block: Avalon-MM register slave,
  configuration register, value window with its pointer, a small
  calendar and the clock output pin. Assumes sys_rst is the power-on
  reset, the unlock key logic outside raises unlock_window for the one
  cycle in which write-enable may be set, and alarm_pulse comes from
  logic on ref_clk.
*/
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`include "rcc_defines.vh"
module rcc_top #(
  parameter TB_DIV = `RCC_TB_DIV,
  parameter TB_PER_SEC = `RCC_TB_HZ
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire unlock_window,
  input wire alarm_pulse,
  output wire clock_out,
  output wire clock_out_oe
);

  ////////////////////////////////////////////////////////////////////
  // Bus handshake and decode
  reg ack_q; // Answer cycle of an access
  reg [31:0] rdata_q; // Read data held for the answer
  wire req; // Any access pending
  wire take; // First cycle of an access: side effects
  wire hit_cfg;
  wire hit_val;
  wire hit_pad;
  wire wr_take;
  wire hi_acc; // Any access of the high window byte

  assign req = avs_read | avs_write;
  assign take = req & ~ack_q;
  assign avs_waitrequest = take;
  assign avs_readdata = rdata_q;
  assign wr_take = take & avs_write;
  assign hit_cfg = (avs_address == `RCC_OFS_CFG);
  assign hit_val = (avs_address == `RCC_OFS_VAL);
  assign hit_pad = (avs_address == `RCC_OFS_PAD);
  assign hi_acc = take & hit_val & avs_byteenable[1];

  ////////////////////////////////////////////////////////////////////
  // Configuration state
  reg en_q; // Module enable
  reg wren_q; // Value write enable
  reg oe_q; // Clock output enable
  reg sel_q; // Output source select
  reg [1:0] ptr_q; // Value window pointer
  reg [7:0] cal_q; // Signed drift calibration
  reg clk_out_q; // Registered pin level
  wire half_flag;
  wire cfg_hi_wr;
  wire cfg_lo_wr;
  wire oe_d; // Output enable as it stands after this edge

  assign cfg_hi_wr = wr_take & hit_cfg & avs_byteenable[1];
  assign cfg_lo_wr = wr_take & hit_cfg & avs_byteenable[0];
  assign oe_d = cfg_hi_wr ? avs_writedata[`RCC_CFG_OE] : oe_q;

  ////////////////////////////////////////////////////////////////////
  // Calendar state, kept in binary
  reg [7:0] sec_q;
  reg [7:0] min_q;
  reg [7:0] hr_q;
  reg [7:0] wd_q;
  reg [7:0] day_q;
  reg [7:0] mon_q;
  reg [7:0] yr_q;
  reg [7:0] win_hi; // Window high byte
  reg [7:0] win_lo; // Window low byte
  wire wr_hi; // Accepted high byte write
  wire wr_lo; // Accepted low byte write
  wire sec_evt;
  wire minute_evt;
  wire raw_tick;
  wire adj_tick;
  wire sub_clr;
  wire [7:0] wd_hi;
  wire [7:0] wd_lo;

  assign wd_hi = avs_writedata[15:8];
  assign wd_lo = avs_writedata[7:0];
  assign wr_hi = wr_take & hit_val & avs_byteenable[1] & wren_q;
  assign wr_lo = wr_take & hit_val & avs_byteenable[0] & wren_q;
  assign sub_clr = wr_lo & (ptr_q == `RCC_PTR_MIN_SEC);
  assign minute_evt = sec_evt & (sec_q >= `RCC_SEC_MAX);

  // Month length; leap years every fourth year
  function [7:0] days_in;
    input [7:0] mon;
    input [7:0] yr;
    begin
      case (mon)
        8'h02: days_in = (yr[1:0] == 2'b00) ? 8'h1d : 8'h1c;
        8'h04, 8'h06, 8'h09, 8'h0b: days_in = 8'h1e;
        default: days_in = 8'h1f;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state, data latched on the first edge
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= take;
      if (take & avs_read)
      begin
        if (hit_cfg)
          rdata_q <= {16'h0000, en_q, 1'b0, wren_q, 1'b0, half_flag,
                      oe_q, ptr_q, cal_q};
        else if (hit_val)
          rdata_q <= {16'h0000, win_hi, win_lo};
        else if (hit_pad)
          rdata_q <= {30'h0000_0000, sel_q, 1'b0};
        else
          rdata_q <= 32'h0000_0000; // Unmapped reads as zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration register; only the power-on reset clears it
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      en_q <= 1'b0;
      wren_q <= 1'b0;
      oe_q <= 1'b0;
      sel_q <= 1'b0;
      ptr_q <= `RCC_PTR_RST;
      cal_q <= `RCC_CAL_RST;
    end
    else
    begin
      if (cfg_hi_wr)
      begin
        // Enable follows the write-enable held before this write
        if (wren_q)
          en_q <= avs_writedata[`RCC_CFG_EN];
        // Setting needs the unlock window; clearing is always allowed
        if (!avs_writedata[`RCC_CFG_WREN])
          wren_q <= 1'b0;
        else if (unlock_window)
          wren_q <= 1'b1;
        oe_q <= avs_writedata[`RCC_CFG_OE];
        ptr_q <= avs_writedata[`RCC_CFG_PTR_HI:`RCC_CFG_PTR_LO];
      end
      else if (hi_acc && ptr_q != `RCC_PTR_MIN_SEC)
        ptr_q <= ptr_q - 2'h1;
      if (cfg_lo_wr)
        cal_q <= avs_writedata[`RCC_CFG_CAL_HI:`RCC_CFG_CAL_LO];
      if (wr_take & hit_pad & avs_byteenable[0])
        sel_q <= avs_writedata[`RCC_PAD_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Window read mux selected by the pointer
  always @*
  begin
    case (ptr_q)
      `RCC_PTR_MIN_SEC:
      begin
        win_hi = min_q;
        win_lo = sec_q;
      end
      `RCC_PTR_WDHR:
      begin
        win_hi = wd_q;
        win_lo = hr_q;
      end
      `RCC_PTR_MTHDAY:
      begin
        win_hi = mon_q;
        win_lo = day_q;
      end
      default:
      begin
        win_hi = 8'h00; // Reserved byte reads zero
        win_lo = yr_q;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Calendar: software writes win over counting in the same cycle.
  // Any value at or past a limit counts as the end, so an out-of-range write still rolls over.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sec_q <= 8'h00;
      min_q <= 8'h00;
      hr_q <= 8'h00;
      wd_q <= 8'h00;
      day_q <= 8'h01;
      mon_q <= 8'h01;
      yr_q <= 8'h00;
    end
    else if (wr_hi | wr_lo)
    begin
      case (ptr_q)
        `RCC_PTR_MIN_SEC:
        begin
          if (wr_hi)
            min_q <= wd_hi;
          if (wr_lo)
            sec_q <= wd_lo;
        end
        `RCC_PTR_WDHR:
        begin
          if (wr_hi)
            wd_q <= wd_hi;
          if (wr_lo)
            hr_q <= wd_lo;
        end
        `RCC_PTR_MTHDAY:
        begin
          if (wr_hi)
            mon_q <= wd_hi;
          if (wr_lo)
            day_q <= wd_lo;
        end
        default:
        begin
          if (wr_lo)
            yr_q <= wd_lo; // High byte reserved, dropped
        end
      endcase
    end
    else if (sec_evt)
    begin
      // Cascade of carries from seconds up to years
      if (sec_q < `RCC_SEC_MAX)
        sec_q <= sec_q + 8'h01;
      else
      begin
        sec_q <= 8'h00;
        if (min_q < `RCC_MIN_MAX)
          min_q <= min_q + 8'h01;
        else
        begin
          min_q <= 8'h00;
          if (hr_q < `RCC_HR_MAX)
            hr_q <= hr_q + 8'h01;
          else
          begin
            hr_q <= 8'h00;
            wd_q <= (wd_q >= `RCC_WD_MAX) ? 8'h00 : wd_q + 8'h01;
            if (day_q < days_in(mon_q, yr_q))
              day_q <= day_q + 8'h01;
            else
            begin
              day_q <= 8'h01;
              if (mon_q < `RCC_MON_MAX)
                mon_q <= mon_q + 8'h01;
              else
              begin
                mon_q <= 8'h01;
                yr_q <= (yr_q >= `RCC_YR_MAX) ? 8'h00 : yr_q + 8'h01;
              end
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock output pin; low and undriven while disabled
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      clk_out_q <= 1'b0;
    // Next enable, so the pin drops in the same edge the enable does
    else if (oe_d)
      clk_out_q <= sel_q ? half_flag : alarm_pulse;
    else
      clk_out_q <= 1'b0;
  end

  assign clock_out = clk_out_q;
  assign clock_out_oe = oe_q;

  ////////////////////////////////////////////////////////////////////
  // Timebase chain: divider, calibration, sub-second counter
  rcc_prescale #(
    .TB_DIV(TB_DIV),
    .TB_PER_SEC(TB_PER_SEC)
  ) u_prescale (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(en_q),
    .adj_tick(adj_tick),
    .sub_clr(sub_clr),
    .raw_tick(raw_tick),
    .sec_evt(sec_evt),
    .half_flag(half_flag)
  );

  // Calibration budget is reloaded at each minute
  rcc_cal_adjust u_cal_adjust (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(en_q),
    .raw_tick(raw_tick),
    .minute_evt(minute_evt),
    .cal(cal_q),
    .adj_tick(adj_tick)
  );
endmodule

// *** rcc_properties.sv ***
/* Checker for the register slave and clock pin of rcc_top.
   Sees only top ports; bound to every rcc_top instance. */
module rcc_properties (
  input wire ref_clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire clock_out,
  input wire clock_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, one reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////
  // Access steps
  sequence req_new;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  // Config write taken with the upper lane
  sequence cfg_take;
    req_wait ##0 avs_write && avs_address == 4'h0 && avs_byteenable[1];
  endsequence

  ////////////////////////////////////////////////////////////////////
  // Bus timing: exactly one wait state
  wait_first_a: assert property (req_new |-> avs_waitrequest)
    else $error("new request without wait state");
  one_wait_a: assert property (req_wait |=> !avs_waitrequest)
    else $error("more than one wait state");
  idle_quiet_a: assert property
    (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait state with no request");
  // Read data contents
  upper_zero_a: assert property (rd_done |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  unmapped_zero_a: assert property
    (rd_done ##0 avs_address == 4'hc |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // Pin gating
  oe_gate_a: assert property (!clock_out_oe |-> !clock_out)
    else $error("pin driven while disabled");
  oe_follow_a: assert property
    (cfg_take |=> clock_out_oe == $past(avs_writedata[10]))
    else $error("pin enable not from written bit");
  reset_clear_a: assert property
    (disable iff (1'b0) sys_rst |=> !clock_out_oe && !clock_out
      && avs_readdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule

bind rcc_top rcc_properties chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .clock_out(clock_out), .clock_out_oe(clock_out_oe));

// *** tb_top.sv ***
/* Self-checking bench for rcc_top: reset values, write lock, pointer,
   value window, half-second flag and clock pin.
   Assumes short timebase parameters: one second is 64 cycles. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] a = 4'h0;
  logic [3:0] be = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic ul = 1'b0; // Unlock window
  logic al = 1'b0; // Alarm pulse
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wq;
  logic co;
  logic coe;
  logic [31:0] q; // Last read data
  logic [7:0] hi;
  logic [7:0] lo;
  logic [7:0] c;
  logic [1:0] p;
  logic o;
  int mismatches = 0;
  int total_checks = 0;
  localparam logic [31:0] NH = 32'hfffff7ff; // Hides running half flag

  rcc_top #(.TB_DIV(4), .TB_PER_SEC(16)) DUT (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .avs_address(a), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wq), .unlock_window(ul), .alarm_pulse(al),
    .clock_out(co), .clock_out_oe(coe));

  ////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  // Expected config word, half flag left zero
  function automatic logic [31:0] cfgv(input logic en, wen, oe,
    input logic [1:0] ptr, input logic [7:0] cal);
    return {16'h0, en, 1'b0, wen, 2'b00, oe, ptr, cal};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // One Avalon access, held until waitrequest is low
  task automatic bus(input logic w, input logic [3:0] ad,
    input logic [31:0] d, input logic [3:0] b);
    @(posedge ref_clk);
    rd <= !w;
    wr <= w;
    a <= ad;
    wd <= d;
    be <= b;
    // Waitrequest and read data are taken at one rising edge
    do @(posedge ref_clk); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Masked read compare
  task automatic rdm(input logic [3:0] ad, input logic [31:0] e, m,
    input string n);
    bus(1'b0, ad, 32'h0, 4'hf);
    chk(n, q & m, e);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    c = $urandom(13);
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Power-on values, unmapped place
    rdm(4'h0, 32'h0, ~32'h0, "cfg");
    rdm(4'h8, 32'h0, ~32'h0, "pad");
    rdm(4'h4, 32'h0, ~32'h0, "min sec");
    rdm(4'hc, 32'h0, ~32'h0, "unmapped");
    $display("test reset done");
    // Enable refused while locked
    bus(1'b1, 4'h0, 32'ha000, 4'h3);
    rdm(4'h0, 32'h0, NH, "locked");
    ul <= 1'b1;
    bus(1'b1, 4'h0, 32'ha000, 4'h3);
    ul <= 1'b0;
    rdm(4'h0, cfgv(0, 1, 0, 2'h0, 8'h0), NH, "en held");
    bus(1'b1, 4'h0, 32'ha000, 4'h3);
    rdm(4'h0, cfgv(1, 1, 0, 2'h0, 8'h0), NH, "en set");
    $display("test lock done");
    // Random fields, extreme calibration codes first
    for (int k = 0; k < 8; k++)
    begin
      {o, p, c} = $urandom;
      if (k < 2)
        c = k ? 8'h80 : 8'h7f;
      bus(1'b1, 4'h0, cfgv(1, 1, o, p, c), 4'h3);
      rdm(4'h0, cfgv(1, 1, o, p, c), NH, "fields");
      chk("oe pin", coe, o);
      // High-byte reads walk the pointer down
      repeat (4)
      begin
        bus(1'b0, 4'h4, 32'h0, 4'h2);
        p = (p == 2'h0) ? 2'h0 : p - 2'h1;
        rdm(4'h0, cfgv(1, 1, o, p, c), NH, "ptr");
      end
    end
    $display("test pointer done");
    // Each window pair, time frozen
    for (int k = 0; k < 4; k++)
    begin
      p = k;
      hi = (k == 2) ? 8'h1 + $urandom % 8'hc : $urandom % 8'h7;
      lo = (k == 2) ? 8'h1 + $urandom % 8'h1c : $urandom % 8'h18;
      bus(1'b1, 4'h0, cfgv(0, 1, 0, p, 8'h0), 4'h3);
      bus(1'b1, 4'h4, {16'h0, hi, lo}, 4'h3);
      rdm(4'h0, cfgv(0, 1, 0, p ? p - 2'h1 : 2'h0, 8'h0), NH, "wptr");
      bus(1'b1, 4'h0, cfgv(0, 1, 0, p, 8'h0), 4'h3);
      rdm(4'h4, {16'h0, (k == 3) ? 8'h0 : hi, lo}, ~32'h0, "win");
    end
    // Window write refused while locked
    bus(1'b1, 4'h0, cfgv(0, 0, 0, 2'h3, 8'h0), 4'h3);
    bus(1'b1, 4'h4, ~32'h0, 4'h1);
    rdm(4'h4, {24'h0, lo}, ~32'h0, "blocked");
    $display("test window done");
    // Half flag restarted by a seconds write
    ul <= 1'b1;
    bus(1'b1, 4'h0, cfgv(0, 1, 0, 2'h0, 8'h0), 4'h3);
    ul <= 1'b0;
    bus(1'b1, 4'h0, cfgv(1, 1, 0, 2'h0, 8'h0), 4'h3);
    bus(1'b1, 4'h4, 32'h0, 4'h1);
    bus(1'b1, 4'h0, cfgv(1, 1, 0, 2'h0, 8'h0) | 32'h800, 4'h3);
    rdm(4'h0, 32'h0, 32'h800, "half low");
    repeat (30) @(posedge ref_clk);
    rdm(4'h0, 32'h800, 32'h800, "half high");
    $display("test half done");
    // Budget of +8 or -8 pulses moves the second after a minute
    for (int k = 0; k < 2; k++)
    begin
      c = k ? 8'hfe : 8'h02;
      bus(1'b1, 4'h0, cfgv(1, 1, 0, 2'h0, c), 4'h3);
      bus(1'b1, 4'h4, 32'h003b, 4'h3);
      repeat (k ? 139 : 107) @(posedge ref_clk);
      rdm(4'h4, {16'h01, 7'h0, !k}, ~32'h0, "cal");
    end
    $display("test calibration done");
    // Pin follows the alarm pulse
    bus(1'b1, 4'h8, 32'h0, 4'h1);
    bus(1'b1, 4'h0, cfgv(1, 1, 1, 2'h0, 8'h0), 4'h3);
    repeat (6)
    begin
      o = $urandom;
      al <= o;
      repeat (2) @(posedge ref_clk);
      chk("pin", co, o);
    end
    bus(1'b1, 4'h8, 32'h2, 4'h1);
    rdm(4'h8, 32'h2, ~32'h0, "pad sel");
    // Seconds clock: low in the first half, high in the second
    bus(1'b1, 4'h4, 32'h0, 4'h1);
    repeat (2) @(posedge ref_clk);
    chk("sec pin low", co, 32'h0);
    repeat (36) @(posedge ref_clk);
    chk("sec pin high", co, 32'h1);
    bus(1'b1, 4'h0, cfgv(1, 1, 0, 2'h0, 8'h0), 4'h3);
    @(negedge ref_clk);
    chk("oe off", coe, 32'h0);
    chk("pin off", co, 32'h0);
    $display("test pin done");
    report_and_stop;
  end
endmodule
